// file: logic/adc_pkg.sv
package adc_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CLOCK     = 8'h04;
  localparam logic [7:0] OFS_DETECT    = 8'h08;
  localparam logic [7:0] OFS_WINDOW    = 8'h0C;
  localparam logic [7:0] OFS_THRESHOLD = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_CRC       = 8'h18;
  localparam logic [7:0] OFS_CH0       = 8'h20;
  localparam logic [7:0] OFS_CH3       = 8'h2C;
  // ==========================================================
  // Field positions
  localparam int CTRL_DETECT_BIT   = 0;
  localparam int CTRL_CRC_INIT_BIT = 1;
  localparam int CTRL_WAKE_BIT     = 2;
  localparam int DET_EN_BIT        = 0;
  localparam int DET_ALL_BIT       = 1;
  localparam int DET_CNT_LSB       = 8;
  localparam int CLK_CHEN_LSB      = 16;
  // ==========================================================
  // Reset values and constants
  localparam logic [15:0] OSR_RST       = 16'h0200;
  localparam logic [3:0]  CHEN_RST      = 4'hF;
  localparam logic [7:0]  DET_CNT_RST   = 8'h08;
  localparam logic [15:0] WINDOW_RST    = 16'h0100;
  localparam logic [23:0] THRESHOLD_RST = 24'h013880;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam int          WORD_BITS     = 24;
  localparam int          NUM_CH        = 4;

  typedef enum {ST_NORMAL, ST_DETECT, ST_STANDBY} adc_state_e;

  typedef struct packed {
    logic [3:0]  ch_en;
    logic [15:0] oversampling_ratio;
  } adc_clock_s;

  typedef struct packed {
    logic        en;
    logic        all_ch;
    logic [7:0]  exceed_cnt;
    logic [15:0] window_len;
    logic [23:0] threshold;
  } adc_detect_s;
endpackage

// file: logic/adc_core.sv
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// - Words are 24 bits and frames carry a 16-bit CCITT CRC.
// - Ready line goes low with results, high when none, after most lagging channel.
// - Detection trips when enabled channels exceed threshold enough times in window.
// - Window length bounds detection activity before returning to standby.
// - Input clock halves to modulator clock; one sample per ratio cycles.
module adc_core #(
  parameter int NUM_CH = adc_pkg::NUM_CH,
  parameter int WBITS  = adc_pkg::WORD_BITS
) (
  input  wire logic                    MCLK_IN,
  input  wire logic                    RST_IN,
  input  wire logic                    PSEL_IN,
  input  wire logic                    PENABLE_IN,
  input  wire logic                    PWRITE_IN,
  input  wire logic [7:0]              PADDR_IN,
  input  wire logic [31:0]             PWDATA_IN,
  output logic      [31:0]             PRDATA_OUT,
  output logic                         PREADY_OUT,
  output logic                         PSLVERR_OUT,
  input  wire logic                    CONVERTER_CLOCK_IN,
  input  wire logic [NUM_CH*WBITS-1:0] CH_DATA_IN,
  output logic                         SAMPLE_READY_N_OUT
);
  // ==========================================================
  // Functions
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [23:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 23; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ({r[14:0], 1'b0} ^ adc_pkg::CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction
  function automatic logic [23:0] mag(input logic [23:0] v);
    return v[23] ? (~v + 24'h000001) : v;
  endfunction
  // ==========================================================
  // Bus decode
  logic                    wr_en;
  logic                    rd_en;
  logic                    mapped;
  adc_pkg::adc_clock_s     clk_cfg_q;
  adc_pkg::adc_detect_s    det_cfg_q;
  adc_pkg::adc_state_e     state_q;
  logic [15:0]             crc_q;
  logic                    ready_q;
  logic                    tamper_q;
  logic [WBITS-1:0]        chan_q [NUM_CH];
  assign wr_en      = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_en      = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
  assign mapped     = (PADDR_IN <= adc_pkg::OFS_CRC || (PADDR_IN >= adc_pkg::OFS_CH0
                      && PADDR_IN <= adc_pkg::OFS_CH3)) && PADDR_IN[1:0] == 2'b00;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
  logic ctrl_wr;
  logic crc_init_wr;
  logic crc_data_wr;
  logic detect_go;
  logic wake_go;
  logic ready_clr;
  assign ctrl_wr     = wr_en && PADDR_IN == adc_pkg::OFS_CTRL;
  assign crc_init_wr = ctrl_wr && PWDATA_IN[adc_pkg::CTRL_CRC_INIT_BIT];
  assign detect_go   = ctrl_wr && PWDATA_IN[adc_pkg::CTRL_DETECT_BIT];
  assign wake_go     = ctrl_wr && PWDATA_IN[adc_pkg::CTRL_WAKE_BIT];
  assign crc_data_wr = wr_en && PADDR_IN == adc_pkg::OFS_CRC;
  assign ready_clr   = rd_en && PADDR_IN == adc_pkg::OFS_CH3;
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      clk_cfg_q <= '{ch_en: adc_pkg::CHEN_RST, oversampling_ratio: adc_pkg::OSR_RST};
      det_cfg_q <= '{en: 1'b0, all_ch: 1'b0, exceed_cnt: adc_pkg::DET_CNT_RST,
                     window_len: adc_pkg::WINDOW_RST, threshold: adc_pkg::THRESHOLD_RST};
    end else if (wr_en) begin
      case (PADDR_IN)
        adc_pkg::OFS_CLOCK: begin
          clk_cfg_q.oversampling_ratio   <= PWDATA_IN[15:0];
          clk_cfg_q.ch_en <= PWDATA_IN[adc_pkg::CLK_CHEN_LSB +: 4];
        end
        adc_pkg::OFS_DETECT: begin
          det_cfg_q.en         <= PWDATA_IN[adc_pkg::DET_EN_BIT];
          det_cfg_q.all_ch     <= PWDATA_IN[adc_pkg::DET_ALL_BIT];
          det_cfg_q.exceed_cnt <= PWDATA_IN[adc_pkg::DET_CNT_LSB +: 8];
        end
        adc_pkg::OFS_WINDOW:    det_cfg_q.window_len <= PWDATA_IN[15:0];
        adc_pkg::OFS_THRESHOLD: det_cfg_q.threshold  <= PWDATA_IN[23:0];
        default: ;
      endcase
    end
  end
  // ==========================================================
  // CRC engine over 24-bit words
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || crc_init_wr) begin
      crc_q <= adc_pkg::CRC_INIT;
    end else if (crc_data_wr) begin
      crc_q <= crc_word(crc_q, PWDATA_IN[WBITS-1:0]);
    end
  end
  // ==========================================================
  // Converter clock sampling and division
  logic        cclk_s1_q;
  logic        cclk_s2_q;
  logic        cclk_s3_q;
  logic        div_q;
  logic [15:0] mod_cnt_q;
  logic        cclk_rise;
  logic        mod_tick;
  logic        sample_tick;
  assign cclk_rise   = cclk_s2_q & ~cclk_s3_q;
  assign mod_tick    = cclk_rise & div_q;
  assign sample_tick = mod_tick && mod_cnt_q == clk_cfg_q.oversampling_ratio - 16'h0001;
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      cclk_s1_q <= 1'b0;
      cclk_s2_q <= 1'b0;
      cclk_s3_q <= 1'b0;
    end else begin
      cclk_s1_q <= CONVERTER_CLOCK_IN;
      cclk_s2_q <= cclk_s1_q;
      cclk_s3_q <= cclk_s2_q;
    end
  end
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      div_q     <= 1'b0;
      mod_cnt_q <= 16'h0000;
    end else begin
      if (cclk_rise) begin
        div_q <= ~div_q;
      end
      if (sample_tick) begin
        mod_cnt_q <= 16'h0000;
      end else if (mod_tick) begin
        mod_cnt_q <= mod_cnt_q + 16'h0001;
      end
    end
  end
  // ==========================================================
  // Sample capture and exceed evaluation
  logic [NUM_CH-1:0] over;
  logic              hit;
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      assign over[g] = clk_cfg_q.ch_en[g]
                       && mag(CH_DATA_IN[g*WBITS +: WBITS]) > det_cfg_q.threshold;
      always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
          chan_q[g] <= '0;
        end else if (sample_tick && clk_cfg_q.ch_en[g]) begin
          chan_q[g] <= CH_DATA_IN[g*WBITS +: WBITS];
        end
      end
    end
  endgenerate
  assign hit = det_cfg_q.all_ch ? (over == clk_cfg_q.ch_en && over != '0) : |over;
  // ==========================================================
  // Mode control and detection window
  logic [15:0] win_cnt_q;
  logic [7:0]  hit_cnt_q;
  logic        trip;
  logic        win_end;
  assign trip    = state_q == adc_pkg::ST_DETECT && sample_tick && hit
                   && hit_cnt_q + 8'h01 >= det_cfg_q.exceed_cnt;
  assign win_end = state_q == adc_pkg::ST_DETECT && sample_tick
                   && win_cnt_q + 16'h0001 >= det_cfg_q.window_len;
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      state_q   <= adc_pkg::ST_NORMAL;
      win_cnt_q <= 16'h0000;
      hit_cnt_q <= 8'h00;
      tamper_q  <= 1'b0;
    end else begin
      case (state_q)
        adc_pkg::ST_NORMAL: begin
          if (detect_go && det_cfg_q.en) begin
            state_q   <= adc_pkg::ST_DETECT;
            win_cnt_q <= 16'h0000;
            hit_cnt_q <= 8'h00;
            tamper_q  <= 1'b0;
          end
        end
        adc_pkg::ST_DETECT: begin
          if (trip || win_end) begin
            state_q  <= adc_pkg::ST_STANDBY;
            tamper_q <= trip;
          end else if (sample_tick) begin
            win_cnt_q <= win_cnt_q + 16'h0001;
            if (hit) begin
              hit_cnt_q <= hit_cnt_q + 8'h01;
            end
          end
        end
        adc_pkg::ST_STANDBY: begin
          if (wake_go) begin
            state_q <= adc_pkg::ST_NORMAL;
          end else if (detect_go && det_cfg_q.en) begin
            state_q   <= adc_pkg::ST_DETECT;
            win_cnt_q <= 16'h0000;
            hit_cnt_q <= 8'h00;
            tamper_q  <= 1'b0;
          end
        end
        default: state_q <= adc_pkg::ST_NORMAL;
      endcase
    end
  end
  // ==========================================================
  // Sample-ready line: set wins over the clearing read
  logic ready_set;
  assign ready_set = (state_q == adc_pkg::ST_NORMAL && sample_tick
                      && clk_cfg_q.ch_en != 4'h0) || trip;
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ready_q <= 1'b0;
    end else if (ready_set) begin
      ready_q <= 1'b1;
    end else if (ready_clr) begin
      ready_q <= 1'b0;
    end
  end
  assign SAMPLE_READY_N_OUT = ~ready_q;
  // ==========================================================
  // Read data
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= 32'h00000000;
    end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      case (PADDR_IN)
        adc_pkg::OFS_CLOCK:     PRDATA_OUT <= {12'h000, clk_cfg_q.ch_en, clk_cfg_q.oversampling_ratio};
        adc_pkg::OFS_DETECT:    PRDATA_OUT <= {16'h0000, det_cfg_q.exceed_cnt, 6'h00,
                                               det_cfg_q.all_ch, det_cfg_q.en};
        adc_pkg::OFS_WINDOW:    PRDATA_OUT <= {16'h0000, det_cfg_q.window_len};
        adc_pkg::OFS_THRESHOLD: PRDATA_OUT <= {8'h00, det_cfg_q.threshold};
        adc_pkg::OFS_STATUS:    PRDATA_OUT <= {24'h000000, hit_cnt_q[3:0], tamper_q,
                                               ready_q, state_q == adc_pkg::ST_STANDBY,
                                               state_q == adc_pkg::ST_DETECT};
        adc_pkg::OFS_CRC:       PRDATA_OUT <= {16'h0000, crc_q};
        8'h20, 8'h24, 8'h28, 8'h2C:
          PRDATA_OUT <= {8'h00, chan_q[PADDR_IN[3:2]]};
        default:                PRDATA_OUT <= 32'h00000000;
      endcase
    end
  end
  // ==========================================================
  // Checks
  AST_DIV_HALF: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    cclk_rise |=> div_q != $past(div_q))
    else $error("modulator divider did not toggle on input edge");
  AST_OSR_COUNT: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    sample_tick |=> mod_cnt_q == 16'h0000)
    else $error("modulator count not restarted at sample");
  AST_OSR_LIMIT: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    mod_cnt_q < clk_cfg_q.oversampling_ratio || $changed(clk_cfg_q))
    else $error("modulator count beyond ratio");
  AST_READY_LOW: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ready_set |=> !SAMPLE_READY_N_OUT)
    else $error("ready line not low after result");
  AST_READY_HIGH: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ready_clr && !ready_set |=> SAMPLE_READY_N_OUT)
    else $error("ready line not high after read");
  AST_TRIP: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    trip |=> state_q == adc_pkg::ST_STANDBY && tamper_q && !SAMPLE_READY_N_OUT)
    else $error("detection trip not signalled");
  AST_WINDOW: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    state_q == adc_pkg::ST_DETECT |-> win_cnt_q < det_cfg_q.window_len || $changed(det_cfg_q))
    else $error("detection outlived window");
  AST_CRC_STEP: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    crc_data_wr && !crc_init_wr |=> crc_q == crc_word($past(crc_q), $past(PWDATA_IN[23:0])))
    else $error("crc step wrong");
  AST_CRC_INIT: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    crc_init_wr |=> crc_q == adc_pkg::CRC_INIT)
    else $error("crc not initialised");
  COV_SAMPLE: cover property (@(posedge MCLK_IN) disable iff (RST_IN)
    sample_tick && state_q == adc_pkg::ST_NORMAL);
  COV_TRIP: cover property (@(posedge MCLK_IN) disable iff (RST_IN) trip);
  COV_WINEND: cover property (@(posedge MCLK_IN) disable iff (RST_IN) win_end && !trip);
endmodule

// file: test/adc_host_model.sv
`timescale 1ns/10ps
// ==========================================
// Host-side converter clock and sample source
module adc_host_model (
  input  wire logic        MCLK_IN,
  input  wire logic        READY_N_IN,
  output logic             CONV_CLK_OUT,
  output logic [95:0]      CH_DATA_OUT
);
  logic       detecting        = 1'b0;
  logic       ready_seen       = 1'b1;
  logic [7:0] tamper_count     = 8'h00;
  logic       tamper_indicator = 1'b0;

  // Falling ready edges while detecting are tamper alerts
  always @(posedge MCLK_IN) begin
    ready_seen <= READY_N_IN;
    if (detecting && ready_seen && !READY_N_IN) begin
      tamper_count <= tamper_count + 8'h01;
    end
  end

  // Power fail: count cleared, indicator off, then detection
  task automatic power_fail();
    @(posedge MCLK_IN);
    tamper_count     <= 8'h00;
    tamper_indicator <= 1'b0;
    detecting        <= 1'b1;
  endtask

  // Power good: indicator on above two alerts, kept until next fail
  task automatic power_good();
    @(posedge MCLK_IN);
    if (tamper_count > 8'h02) begin
      tamper_indicator <= 1'b1;
    end
    detecting <= 1'b0;
  endtask
  initial begin
    CONV_CLK_OUT = 1'b0; // Clock held off while the converter is set up
    CH_DATA_OUT  = 96'h0;
  end

  // Order: 0 voltage, 1 shunt, 2 transformer, 3 unused
  task automatic load(input logic [23:0] c3, input logic [23:0] c2,
                      input logic [23:0] c1, input logic [23:0] c0);
    CH_DATA_OUT <= {c3, c2, c1, c0};
  endtask

  // Bursts only after setup; the clock stands low between them
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge MCLK_IN);
      CONV_CLK_OUT <= 1'b1;
      repeat (3) @(posedge MCLK_IN);
      CONV_CLK_OUT <= 1'b0;
      repeat (2) @(posedge MCLK_IN);
    end
  endtask
endmodule

// file: test/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_clk;
  logic        ready_n;
  logic [95:0] ch_data;
  logic [31:0] rv;
  logic        ev;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;

  always #4 clk = ~clk;

  adc_core i_adc_core (
    .MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CONVERTER_CLOCK_IN(conv_clk),
    .CH_DATA_IN(ch_data), .SAMPLE_READY_N_OUT(ready_n)
  );

  adc_host_model i_adc_host_model (
    .MCLK_IN(clk), .READY_N_IN(ready_n), .CONV_CLK_OUT(conv_clk), .CH_DATA_OUT(ch_data)
  );

  // ==========================================
  // Bus and compare helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    check(rv & m, e);
  endtask

  task automatic samples(input int n);
    i_adc_host_model.ticks(8 * n);
    repeat (5) @(posedge clk);
  endtask

  task automatic pin(input logic e);
    check({31'h0, ready_n}, {31'h0, e});
  endtask

  task automatic lamp(input logic e);
    @(posedge clk);
    check({31'h0, i_adc_host_model.tamper_indicator}, {31'h0, e});
  endtask

  function automatic logic [15:0] crc(input logic [15:0] c, input logic [23:0] d);
    logic fb;
    for (int i = 23; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0} ^ (fb ? adc_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ==========================================
  // Test sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(adc_pkg::OFS_CLOCK, 32'hFFFFFFFF, 32'h000F0200);
    rd(adc_pkg::OFS_DETECT, 32'hFFFFFFFF, 32'h00000800);
    rd(adc_pkg::OFS_WINDOW, 32'hFFFFFFFF, 32'h00000100);
    rd(adc_pkg::OFS_THRESHOLD, 32'hFFFFFFFF, 32'h00013880);
    rd(adc_pkg::OFS_CRC, 32'h0000FFFF, 32'h0000FFFF);
    rd(8'h1C, 32'hFFFFFFFF, 32'h00000000);
    check({31'h0, ev}, 32'h00000001);
    rd(8'h02, 32'hFFFFFFFF, 32'h00000000);
    check({31'h0, ev}, 32'h00000001);
    $display("test defaults done");
    wr(adc_pkg::OFS_CTRL, 32'h00000002);
    wr(adc_pkg::OFS_CRC, 32'h00123456);
    wr(adc_pkg::OFS_CRC, 32'h00ABCDEF);
    rd(adc_pkg::OFS_CRC, 32'h0000FFFF,
       {16'h0000, crc(crc(adc_pkg::CRC_INIT, 24'h123456), 24'hABCDEF)});
    $display("test crc done");
    wr(adc_pkg::OFS_CLOCK, 32'h000F0004);
    i_adc_host_model.load(24'h123456, 24'h000000, 24'h000000, 24'hABCDEF);
    i_adc_host_model.ticks(7);
    repeat (5) @(posedge clk);
    pin(1'b1);
    i_adc_host_model.ticks(1);
    repeat (5) @(posedge clk);
    pin(1'b0);
    rd(adc_pkg::OFS_STATUS, 32'h00000004, 32'h00000004);
    rd(adc_pkg::OFS_CH0, 32'hFFFFFFFF, 32'h00ABCDEF);
    pin(1'b0);
    rd(adc_pkg::OFS_CH3, 32'hFFFFFFFF, 32'h00123456);
    repeat (2) @(posedge clk);
    pin(1'b1);
    $display("test sampling done");
    wr(adc_pkg::OFS_WINDOW, 32'h00000010);
    wr(adc_pkg::OFS_DETECT, 32'h00000201);
    i_adc_host_model.power_fail();
    wr(adc_pkg::OFS_CTRL, 32'h00000001);
    i_adc_host_model.load(24'h000000, 24'h000000, 24'h013880, 24'h000000);
    samples(1);
    rd(adc_pkg::OFS_STATUS, 32'h0000000F, 32'h00000001);
    pin(1'b1);
    i_adc_host_model.load(24'h000000, 24'h000000, 24'h013881, 24'h000000);
    samples(1);
    rd(adc_pkg::OFS_STATUS, 32'h0000000F, 32'h00000001);
    i_adc_host_model.load(24'h000000, 24'hFEC77F, 24'h000000, 24'h000000);
    samples(1);
    rd(adc_pkg::OFS_STATUS, 32'h0000000F, 32'h0000000E);
    pin(1'b0);
    check({24'h0, i_adc_host_model.tamper_count}, 32'h00000001);
    i_adc_host_model.power_good();
    lamp(1'b0);
    rd(adc_pkg::OFS_CH3, 32'hFFFFFFFF, 32'h00000000);
    wr(adc_pkg::OFS_CTRL, 32'h00000004);
    rd(adc_pkg::OFS_STATUS, 32'h00000007, 32'h00000000);
    $display("test detect trip done");
    wr(adc_pkg::OFS_WINDOW, 32'h00000003);
    wr(adc_pkg::OFS_DETECT, 32'h00000801);
    wr(adc_pkg::OFS_CTRL, 32'h00000001);
    i_adc_host_model.load(24'h000000, 24'h000000, 24'h000000, 24'hFEC780);
    samples(2);
    rd(adc_pkg::OFS_STATUS, 32'h00000007, 32'h00000001);
    samples(1);
    rd(adc_pkg::OFS_STATUS, 32'h00000007, 32'h00000002);
    pin(1'b1);
    wr(adc_pkg::OFS_CTRL, 32'h00000004);
    $display("test detect window done");
    i_adc_host_model.power_fail();
    wr(adc_pkg::OFS_DETECT, 32'h00000103);
    i_adc_host_model.load(24'h000000, 24'h000000, 24'h000000, 24'h013881);
    wr(adc_pkg::OFS_CTRL, 32'h00000001);
    samples(1);
    rd(adc_pkg::OFS_STATUS, 32'h0000000F, 32'h00000001);
    wr(adc_pkg::OFS_CLOCK, 32'h00010004);
    for (int k = 0; k < 3; k++) begin
      if (k > 0) wr(adc_pkg::OFS_CTRL, 32'h00000001);
      samples(1);
      rd(adc_pkg::OFS_STATUS, 32'h0000000F, 32'h0000000E);
      rd(adc_pkg::OFS_CH3, 32'hFFFFFFFF, 32'h00000000);
    end
    check({24'h0, i_adc_host_model.tamper_count}, 32'h00000003);
    i_adc_host_model.power_good();
    lamp(1'b1);
    wr(adc_pkg::OFS_CTRL, 32'h00000004);
    wr(adc_pkg::OFS_CLOCK, 32'h000F0004);
    rd(adc_pkg::OFS_STATUS, 32'h00000007, 32'h00000000);
    lamp(1'b1);
    i_adc_host_model.power_fail();
    lamp(1'b0);
    $display("test all channels and tamper lamp done");
    end_of_test();
  end
endmodule
